/* src/vmsc_regs.svh */
// offsets, field positions, reset values and timing counts for the mode and start-up control
`ifndef VMSC_REGS_SVH
`define VMSC_REGS_SVH

`define VMSC_CLK_PERIOD_NS    100
`define VMSC_SS_TIME_NS       200000
`define VMSC_SS_CYCLES        ((`VMSC_SS_TIME_NS + `VMSC_CLK_PERIOD_NS - 1) / `VMSC_CLK_PERIOD_NS)
`define VMSC_PH_SAMPLE_CYC    4

`define VMSC_OFF_STATUS       4'h0
`define VMSC_OFF_MASK         4'h1
`define VMSC_OFF_CONTROL      4'h2
`define VMSC_OFF_STATE        4'h3

`define VMSC_EV_ENABLE_RISE   0
`define VMSC_EV_SYSTEM_POWER_OK_RISE    1
`define VMSC_EV_SYSTEM_POWER_OK_FALL    2
`define VMSC_EV_FAULT         3
`define VMSC_EV_PGOOD_CHANGE  4
`define VMSC_EV_LINK_EDGE     5
`define VMSC_EV_WIDTH         6

`define VMSC_CTL_FAULT_INJECT 0
`define VMSC_MASK_RESET       6'h00

`endif

/* src/vmsc_pkg.sv */
// types shared by the mode and start-up control
package vmsc_pkg;
   typedef enum logic [1:0] {
      VMSC_MODE_NONE,
      VMSC_MODE_PARALLEL,
      VMSC_MODE_SERIAL
   } vmsc_mode_t;

   typedef enum logic [2:0] {
      VMSC_ST_DISABLED,
      VMSC_ST_DETECT,
      VMSC_ST_SOFTSTART,
      VMSC_ST_RUN,
      VMSC_ST_FAULT
   } vmsc_state_t;
endpackage

/* src/vmsc_sync2.sv */
// two-flop synchroniser for a bundle of asynchronous levels
`timescale 1ns/1ps
module vmsc_sync2 #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         nrst,
   // levels
   input  wire logic [W-1:0] asyncIn,
   output logic      [W-1:0] syncOut
);
   logic [W-1:0] stage1_q;
   logic [W-1:0] stage1_d;
   logic [W-1:0] stage2_q;
   logic [W-1:0] stage2_d;

   always_comb begin
      stage1_d = asyncIn;
      stage2_d = stage1_q;
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         stage1_q <= '0;
         stage2_q <= '0;
      end else begin
         stage1_q <= stage1_d;
         stage2_q <= stage2_d;
      end
   end

   assign syncOut = stage2_q;
endmodule

/* src/vmsc_mode_startup.sv */
// mode detection, boot code latch, power-good and driver enables of the regulator controller
`timescale 1ns/1ps
`include "vmsc_regs.svh"
module vmsc_mode_startup
   import vmsc_pkg::*;
#(
   parameter int SS_CYCLES = `VMSC_SS_CYCLES
) (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       nrst,
   // processor side pins
   input  wire logic       enable,
   input  wire logic       protocolSelectPin,
   input  wire logic       parallelCodeBitZero,
   input  wire logic [5:0] parallelCode,
   input  wire logic       serialVidClock,
   input  wire logic       serialVidData,
   input  wire logic       systemPowerOk,
   // analog monitor levels
   input  wire logic       coreInSpec,
   input  wire logic       bridgeInSpec,
   input  wire logic       faultDetect,
   input  wire logic       pwm3Grounded,
   input  wire logic       pwm4Grounded,
   // core loop pwm requests
   input  wire logic [3:0] corePwmRequest,
   input  wire logic       bridgePwmRequest,
   // register port
   input  wire logic [3:0] regAddr,
   input  wire logic [7:0] regWdata,
   input  wire logic       regWrite,
   input  wire logic       regRead,
   output logic      [7:0] regRdata,
   output logic            irq,
   // results
   output logic [1:0]      bootVoltageCode,
   output logic [5:0]      targetCode,
   output logic            targetFromBoot,
   output logic            serialProcessEnable,
   output logic            serialMode,
   output logic [2:0]      corePhaseCount,
   // open-drain and three-state pins, then the driven fault flag
   output logic            railPowerGoodOut,
   output logic            railPowerGoodOe,
   output logic            bridgeDriverEnableOut,
   output logic            bridgeDriverEnableOe,
   output logic            coreDriverEnableOut,
   output logic            coreDriverEnableOe,
   output logic            bridgePwmOut,
   output logic            bridgePwmOe,
   output logic [3:0]      corePhaseOutputs,
   output logic [3:0]      corePhaseOe,
   output logic            faultFlagPin
);
   localparam int SYNC_W = 16;
   localparam int CNT_W  = 32;
   logic [SYNC_W-1:0] syncIn;
   logic [SYNC_W-1:0] syncOut;
   logic       enS;
   logic       selS;
   logic       bit0S;
   logic [5:0] codeS;
   logic       sclkS;
   logic       sdatS;
   logic       pokS;
   logic       coreOkS;
   logic       brOkS;
   logic       faultS;
   logic       p3gS;
   logic       p4gS;

   // every processor pin and analog monitor level is double flopped before use; the pwm requests are not
   assign syncIn = {pwm4Grounded, pwm3Grounded, faultDetect, bridgeInSpec, coreInSpec, systemPowerOk,
                    serialVidData, serialVidClock, parallelCode[5:1], parallelCodeBitZero,
                    protocolSelectPin, enable};

   vmsc_sync2 #(.W(SYNC_W)) uSync (
      .clk     (clk),
      .nrst    (nrst),
      .asyncIn (syncIn),
      .syncOut (syncOut)
   );

   assign enS     = syncOut[0];
   assign selS    = syncOut[1];
   assign bit0S   = syncOut[2];
   assign codeS   = {syncOut[7:3], bit0S};
   assign sclkS   = syncOut[8];
   assign sdatS   = syncOut[9];
   assign pokS    = syncOut[10];
   assign coreOkS = syncOut[11];
   assign brOkS   = syncOut[12];
   assign faultS  = syncOut[13];
   assign p3gS    = syncOut[14];
   assign p4gS    = syncOut[15];

   // sequencing state
   vmsc_state_t state_q;
   vmsc_state_t state_d;
   vmsc_mode_t  mode_q;
   vmsc_mode_t  mode_d;
   logic             enPrev_q;
   logic             enPrev_d;
   logic             pokPrev_q;
   logic             pokPrev_d;
   logic             sclkPrev_q;
   logic             sclkPrev_d;
   logic [1:0]       boot_q;
   logic [1:0]       boot_d;
   logic             bootValid_q;
   logic             bootValid_d;
   logic [CNT_W-1:0] ssCnt_q;
   logic [CNT_W-1:0] ssCnt_d;
   logic [2:0]       phases_q;
   logic [2:0]       phases_d;
   logic [5:0]       target_q;
   logic [5:0]       target_d;
   logic             pgood_q;
   logic             pgood_d;
   logic             fault_q;
   logic             fault_d;
   logic             enRise;
   logic             pokRise;
   logic             pokFall;
   logic             linkEdge;
   logic             planesOk;
   logic             injectFault;

   assign enRise   = enS && !enPrev_q;
   assign pokRise  = pokS && !pokPrev_q;
   assign pokFall  = !pokS && pokPrev_q;
   assign linkEdge = sclkS && !sclkPrev_q;

   // parallel mode ignores the bridge plane for power good
   assign planesOk = (mode_q == VMSC_MODE_PARALLEL) ? coreOkS : (coreOkS && brOkS);
   always_comb begin
      state_d     = state_q;
      mode_d      = mode_q;
      boot_d      = boot_q;
      bootValid_d = bootValid_q;
      ssCnt_d     = ssCnt_q;
      phases_d    = phases_q;
      target_d    = target_q;
      pgood_d     = 1'b0;
      fault_d     = fault_q;
      enPrev_d    = enS;
      pokPrev_d   = pokS;
      sclkPrev_d  = sclkS;
      case (state_q)
         VMSC_ST_DISABLED: begin
            // enable low holds everything off; cycling it clears the latches
            mode_d      = VMSC_MODE_NONE;
            boot_d      = 2'h0;
            bootValid_d = 1'b0;
            fault_d     = 1'b0;
            ssCnt_d     = '0;
            if (enRise) begin
               state_d = VMSC_ST_DETECT;
            end
         end
         VMSC_ST_DETECT: begin
            // protocol fixed from the select pin sampled at the edge
            mode_d = selS ? VMSC_MODE_PARALLEL : VMSC_MODE_SERIAL;
            if (!selS) begin
               boot_d      = {sclkS, sdatS};
               bootValid_d = 1'b1;
            end
            // phase count strapped by grounded pwm pins
            if (p3gS && p4gS) begin
               phases_d = 3'h2;
            end else if (p4gS) begin
               phases_d = 3'h3;
            end else begin
               phases_d = 3'h4;
            end
            state_d = VMSC_ST_SOFTSTART;
         end
         VMSC_ST_SOFTSTART: begin
            ssCnt_d = ssCnt_q + CNT_W'(1);
            if (ssCnt_q >= CNT_W'(SS_CYCLES - 1)) begin
               state_d = VMSC_ST_RUN;
            end
         end
         VMSC_ST_RUN: begin
            pgood_d = planesOk;
         end
         VMSC_ST_FAULT: begin
            fault_d = 1'b1;
         end
         default: begin
            state_d = VMSC_ST_DISABLED;
         end
      endcase
      // target source: boot code until power ok, parallel code only in parallel mode
      if (mode_d == VMSC_MODE_PARALLEL) begin
         target_d = codeS;
      end else if (!pokS) begin
         target_d = {4'h0, boot_d};
      end
      if ((state_q == VMSC_ST_SOFTSTART || state_q == VMSC_ST_RUN) && (faultS || injectFault)) begin
         state_d = VMSC_ST_FAULT;
         fault_d = 1'b1;
         pgood_d = 1'b0;
      end
      if (!enS) begin
         state_d = VMSC_ST_DISABLED;
         pgood_d = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         state_q     <= VMSC_ST_DISABLED;
         mode_q      <= VMSC_MODE_NONE;
         boot_q      <= 2'h0;
         bootValid_q <= 1'b0;
         ssCnt_q     <= '0;
         phases_q    <= 3'h4;
         target_q    <= 6'h00;
         pgood_q     <= 1'b0;
         fault_q     <= 1'b0;
         enPrev_q    <= 1'b0;
         pokPrev_q   <= 1'b0;
         sclkPrev_q  <= 1'b0;
      end else begin
         state_q     <= state_d;
         mode_q      <= mode_d;
         boot_q      <= boot_d;
         bootValid_q <= bootValid_d;
         ssCnt_q     <= ssCnt_d;
         phases_q    <= phases_d;
         target_q    <= target_d;
         pgood_q     <= pgood_d;
         fault_q     <= fault_d;
         enPrev_q    <= enPrev_d;
         pokPrev_q   <= pokPrev_d;
         sclkPrev_q  <= sclkPrev_d;
      end
   end

   // register file: sticky status, mask, control
   logic [`VMSC_EV_WIDTH-1:0] status_q;
   logic [`VMSC_EV_WIDTH-1:0] status_d;
   logic [`VMSC_EV_WIDTH-1:0] mask_q;
   logic [`VMSC_EV_WIDTH-1:0] mask_d;
   logic [7:0]                ctrl_q;
   logic [7:0]                ctrl_d;
   logic [7:0]                rdata_q;
   logic [7:0]                rdata_d;
   logic [`VMSC_EV_WIDTH-1:0] events;

   assign events = {linkEdge && (mode_q == VMSC_MODE_SERIAL), pgood_d != pgood_q,
                    fault_d && !fault_q, pokFall, pokRise, enRise};
   assign injectFault = ctrl_q[`VMSC_CTL_FAULT_INJECT];

   always_comb begin
      status_d = status_q;
      mask_d   = mask_q;
      ctrl_d   = ctrl_q;
      rdata_d  = 8'h00;
      if (regWrite) begin
         case (regAddr)
            `VMSC_OFF_STATUS:  status_d = status_q & ~regWdata[`VMSC_EV_WIDTH-1:0];
            `VMSC_OFF_MASK:    mask_d   = regWdata[`VMSC_EV_WIDTH-1:0];
            `VMSC_OFF_CONTROL: ctrl_d   = regWdata;
            default:           ;
         endcase
      end
      // a new event wins over a clear in the same cycle
      status_d = status_d | events;
      if (regRead) begin
         case (regAddr)
            `VMSC_OFF_STATUS:  rdata_d = {2'h0, status_q};
            `VMSC_OFF_MASK:    rdata_d = {2'h0, mask_q};
            `VMSC_OFF_CONTROL: rdata_d = ctrl_q;
            `VMSC_OFF_STATE:   rdata_d = {bootValid_q, boot_q, mode_q, state_q};
            default:           rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         status_q <= '0;
         mask_q   <= `VMSC_MASK_RESET;
         ctrl_q   <= 8'h00;
         rdata_q  <= 8'h00;
      end else begin
         status_q <= status_d;
         mask_q   <= mask_d;
         ctrl_q   <= ctrl_d;
         rdata_q  <= rdata_d;
      end
   end

   assign regRdata = rdata_q;
   assign irq      = |(status_q & mask_q);

   // outputs
   logic running;
   logic bridgeActive;
   assign running      = (state_q == VMSC_ST_SOFTSTART) || (state_q == VMSC_ST_RUN);
   // bridge plane only runs in serial mode
   assign bridgeActive = running && (mode_q == VMSC_MODE_SERIAL);

   assign bootVoltageCode     = boot_q;
   assign targetCode          = target_q;
   assign serialMode          = (mode_q == VMSC_MODE_SERIAL);
   assign targetFromBoot      = serialMode && !pokS;
   assign serialProcessEnable = serialMode && pokS && running;
   assign corePhaseCount      = phases_q;

   // open drain: enable high pulls the pin low; released pin reads high via pull-up
   assign railPowerGoodOut      = 1'b0;
   assign railPowerGoodOe       = !pgood_q;
   assign coreDriverEnableOut   = 1'b0;
   assign coreDriverEnableOe    = !running;
   assign bridgeDriverEnableOut = 1'b0;
   assign bridgeDriverEnableOe  = !bridgeActive;
   assign bridgePwmOut          = bridgePwmRequest;
   assign bridgePwmOe           = bridgeActive;

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : gPhase
         assign corePhaseOutputs[gi] = corePwmRequest[gi];
         assign corePhaseOe[gi]      = running && (gi < int'(phases_q));
      end
   endgenerate

   assign faultFlagPin = fault_q;

   chk_boot_hold_power: assert property (@(posedge clk) disable iff (!nrst)
      (state_q == VMSC_ST_RUN && $stable(enS)) |=> $stable(boot_q))
      else $error("boot code changed while running");
   chk_fault_latched: assert property (@(posedge clk) disable iff (!nrst)
      (fault_q && enS && state_q != VMSC_ST_DISABLED) |=> fault_q)
      else $error("fault flag dropped without enable cycling");
   chk_bridge_parallel_hiz: assert property (@(posedge clk) disable iff (!nrst)
      (mode_q == VMSC_MODE_PARALLEL) |-> (bridgeDriverEnableOe && !bridgePwmOe))
      else $error("bridge active in parallel mode");
   chk_pgood_softstart: assert property (@(posedge clk) disable iff (!nrst)
      (!railPowerGoodOe) |-> $past(state_q) == VMSC_ST_RUN)
      else $error("power good released outside run");
   chk_detect_on_enable: assert property (@(posedge clk) disable iff (!nrst)
      (state_q == VMSC_ST_DISABLED && enRise) |=> (state_q == VMSC_ST_DETECT)) else $error("no detect after enable");
   chk_mode_from_select: assert property (@(posedge clk) disable iff (!nrst)
      (state_q == VMSC_ST_DETECT && selS) |=> (mode_q == VMSC_MODE_PARALLEL)) else $error("select high not parallel");
endmodule

/* testbench/vmsc_cpu_model.sv */
// processor-side model: enable, protocol strap, code pins, serial link and power ok
`timescale 1ns/1ps
module vmsc_cpu_model (
   // clock used only to time pin changes
   input  wire logic  clk,
   // pins toward the controller
   output logic       enable,
   output logic       protocolSelectPin,
   output logic       parallelCodeBitZero,
   output logic [5:0] parallelCode,
   output logic       serialVidClock,
   output logic       serialVidData,
   output logic       systemPowerOk
);
   initial begin
      {enable, protocolSelectPin, parallelCodeBitZero, serialVidClock, serialVidData, systemPowerOk} = 6'h00;
      parallelCode = 6'h00;
   end

   // strap pins are settled four cycles ahead so they are valid at the enable edge
   task automatic powerUp(input logic sel, input logic [1:0] boot, input logic [5:0] code);
      @(posedge clk);
      enable <= 1'b0;
      protocolSelectPin <= sel;
      {serialVidClock, serialVidData} <= boot;
      parallelCode <= code;
      parallelCodeBitZero <= code[0];
      repeat (4) @(posedge clk);
      enable <= 1'b1;
      repeat (8) @(posedge clk);
      // serial lines fall back to their pull-down once the boot code is taken
      if (!sel) begin
         {serialVidClock, serialVidData} <= 2'h0;
      end
   endtask

   task automatic powerDown();
      @(posedge clk);
      enable <= 1'b0;
   endtask

   task automatic setPok(input logic v);
      @(posedge clk);
      systemPowerOk <= v;
   endtask

   // one byte at an 800 ns link period; the link clock stands low outside frames
   task automatic frame(input logic [7:0] b);
      @(posedge clk);
      for (int i = 7; i >= 0; i--) begin
         serialVidData <= b[i];
         serialVidClock <= 1'b0;
         repeat (4) @(posedge clk);
         serialVidClock <= 1'b1;
         repeat (4) @(posedge clk);
      end
      serialVidClock <= 1'b0;
      serialVidData <= 1'b0;
   endtask
endmodule

/* testbench/tb_vr_mode_startup_control.sv */
// self-checking bench for the mode and start-up control
`timescale 1ns/1ps
`include "vmsc_regs.svh"
module tb_vr_mode_startup_control;
   import vmsc_pkg::*;
   localparam int SsCycles = 10;
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic        enable, protocolSelectPin, parallelCodeBitZero, serialVidClock, serialVidData, systemPowerOk;
   logic [5:0]  parallelCode, targetCode;
   logic        coreInSpec, bridgeInSpec, faultDetect, pwm3Grounded, pwm4Grounded, bridgePwmRequest;
   logic [3:0]  corePwmRequest, regAddr, corePhaseOutputs, corePhaseOe;
   logic [7:0]  regWdata, regRdata;
   logic        regWrite, regRead, irq, targetFromBoot, serialProcessEnable, serialMode;
   logic [1:0]  bootVoltageCode;
   logic [2:0]  corePhaseCount;
   logic        railPowerGoodOut, railPowerGoodOe, bridgeDriverEnableOut, bridgeDriverEnableOe;
   logic        coreDriverEnableOut, coreDriverEnableOe, bridgePwmOut, bridgePwmOe, faultFlagPin;
   logic [7:0]  expQ[$];
   logic        rdPend = 1'b0;
   logic [31:0] rng = 32'h34;
   int          errors = 0;
   int          cmpCount = 0;

   always #50 clk = ~clk;

   vmsc_cpu_model u_cpu (.clk, .enable, .protocolSelectPin, .parallelCodeBitZero, .parallelCode,
      .serialVidClock, .serialVidData, .systemPowerOk);

   vmsc_mode_startup #(.SS_CYCLES(SsCycles)) u_dut (.clk, .nrst, .enable, .protocolSelectPin,
      .parallelCodeBitZero, .parallelCode, .serialVidClock, .serialVidData, .systemPowerOk, .coreInSpec,
      .bridgeInSpec, .faultDetect, .pwm3Grounded, .pwm4Grounded, .corePwmRequest, .bridgePwmRequest,
      .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .irq, .bootVoltageCode, .targetCode,
      .targetFromBoot, .serialProcessEnable, .serialMode, .corePhaseCount, .railPowerGoodOut,
      .railPowerGoodOe, .bridgeDriverEnableOut, .bridgeDriverEnableOe, .coreDriverEnableOut,
      .coreDriverEnableOe, .bridgePwmOut, .bridgePwmOe, .corePhaseOutputs, .corePhaseOe, .faultFlagPin);

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmpCount++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic conclude();
      if (errors == 0 && cmpCount > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      expQ.push_back(e);
      @(posedge clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe, so they are taken at the edge closing it
   always @(posedge clk) begin
      rdPend <= regRead;
      if (rdPend)
         chk(regRdata, expQ.pop_front());
   end

   initial begin
      #(20000 * 100);
      errors++;
      conclude();
   end

   initial begin
      {regWrite, regRead, faultDetect, pwm3Grounded, pwm4Grounded, bridgePwmRequest} = 6'h00;
      {coreInSpec, bridgeInSpec} = 2'h3;
      regAddr = 4'h0;
      regWdata = 8'h00;
      corePwmRequest = 4'h0;
      cyc(8);
      nrst <= 1'b1;
      cyc(1);
      chk(railPowerGoodOe, 8'h01);
      chk(corePhaseOe, 8'h00);
      chk(faultFlagPin, 8'h00);
      chk({railPowerGoodOut, coreDriverEnableOut, bridgeDriverEnableOut}, 8'h00);
      rd(`VMSC_OFF_MASK, {2'h0, `VMSC_MASK_RESET});
      wr(4'hF, 8'hFF);
      rd(4'hF, 8'h00);
      rd(`VMSC_OFF_STATE, 8'h00);
      // every boot code; each power-up cycles enable, so the latch must retake the new pins
      for (int b = 0; b < 4; b++) begin
         rng = xs(rng);
         corePwmRequest <= rng[3:0];
         bridgePwmRequest <= rng[4];
         u_cpu.powerUp(1'b0, b[1:0], rng[10:5]);
         cyc(25);
         chk(serialMode, 8'h01);
         chk({6'h00, bootVoltageCode}, {6'h00, b[1:0]});
         chk(targetFromBoot, 8'h01);
         chk(serialProcessEnable, 8'h00);
         chk(coreDriverEnableOe, 8'h00);
         chk(bridgeDriverEnableOe, 8'h00);
         chk(railPowerGoodOe, 8'h00);
         chk(irq, 8'h00);
         chk({2'h0, targetCode}, {6'h00, b[1:0]});
         chk(corePhaseOe, 8'h0F);
         chk(bridgePwmOe, 8'h01);
         chk({4'h0, corePhaseOutputs}, {4'h0, corePwmRequest});
         chk(bridgePwmOut, bridgePwmRequest);
         rd(`VMSC_OFF_STATE, {1'b1, b[1:0], VMSC_MODE_SERIAL, VMSC_ST_RUN});
      end
      u_cpu.setPok(1'b1);
      cyc(5);
      chk(serialProcessEnable, 8'h01);
      chk(targetFromBoot, 8'h00);
      wr(`VMSC_OFF_STATUS, 8'h3F);
      rng = xs(rng);
      u_cpu.frame(rng[7:0]);
      cyc(4);
      rd(`VMSC_OFF_STATUS, 8'h20);
      u_cpu.setPok(1'b0);
      cyc(5);
      chk(targetFromBoot, 8'h01);
      chk({6'h00, bootVoltageCode}, 8'h03);
      chk({2'h0, targetCode}, 8'h03);
      bridgeInSpec <= 1'b0;
      cyc(5);
      chk(railPowerGoodOe, 8'h01);
      bridgeInSpec <= 1'b1;
      wr(`VMSC_OFF_MASK, 8'h08);
      wr(`VMSC_OFF_STATUS, 8'h3F);
      faultDetect <= 1'b1;
      cyc(4);
      faultDetect <= 1'b0;
      cyc(4);
      chk(faultFlagPin, 8'h01);
      chk(irq, 8'h01);
      wr(`VMSC_OFF_STATUS, 8'h08);
      cyc(2);
      chk(irq, 8'h00);
      chk(faultFlagPin, 8'h01);
      rd(`VMSC_OFF_MASK, 8'h08);
      u_cpu.powerDown();
      cyc(5);
      chk(faultFlagPin, 8'h00);
      chk(coreDriverEnableOe, 8'h01);
      rd(`VMSC_OFF_STATE, 8'h00);
      // straps for four, three and two core phases
      for (int p = 0; p < 3; p++) begin
         pwm4Grounded <= (p > 0);
         pwm3Grounded <= (p > 1);
         rng = xs(rng);
         u_cpu.powerUp(1'b1, rng[1:0], rng[7:2]);
         cyc(25);
         chk(serialMode, 8'h00);
         chk({5'h00, corePhaseCount}, 8'(4 - p));
         chk(bridgeDriverEnableOe, 8'h01);
         chk(bridgePwmOe, 8'h00);
         chk(corePhaseOe, 8'(4'hF >> p));
         chk({2'h0, targetCode}, {2'h0, rng[7:2]});
         bridgeInSpec <= 1'b0;
         cyc(5);
         chk(railPowerGoodOe, 8'h00);
         bridgeInSpec <= 1'b1;
      end
      // fault injection through the control register latches the fault pin
      wr(`VMSC_OFF_CONTROL, 8'h01);
      cyc(2);
      chk(faultFlagPin, 8'h01);
      rd(`VMSC_OFF_CONTROL, 8'h01);
      cyc(2);
      conclude();
   end
endmodule
